// ---- common/aopc_pkg.sv ----
// Purpose: Shared constants for the output port control block
// Assumes: Microport carries 16-bit data and a channel address
// Notes:   Offsets are channel addresses behind the indirect pointer
package aopc_pkg;
  localparam logic [7:0] OFS_HB_A      = 8'h08;
  localparam logic [7:0] OFS_HB_B      = 8'h09;
  localparam logic [7:0] OFS_GL_CTRL   = 8'h0A;
  localparam logic [7:0] OFS_GL_HOLD   = 8'h0B;
  localparam logic [7:0] OFS_LINK_A    = 8'h1B;
  localparam logic [7:0] OFS_PAR_B     = 8'h1C;
  localparam logic [7:0] OFS_LINK_B    = 8'h1D;
  localparam logic [7:0] OFS_OCLK      = 8'h1E;
  // Field positions
  localparam int HB_BYPASS_BIT   = 0;
  localparam int HB_SEL_LO       = 1;
  localparam int GL_BYPASS_BIT   = 0;
  localparam int GL_FIRST_BIT    = 1;
  localparam int GL_INIT_BIT     = 2;
  localparam int GL_NOW_BIT      = 3;
  localparam int GL_CLIP_BIT     = 4;
  localparam int GL_WL_LO        = 5;
  localparam int PP_SRC_BIT      = 0;
  localparam int PP_CHEN_LO      = 1;
  localparam int PP_FMT_BIT      = 5;
  localparam int LP_SRC_BIT      = 0;
  localparam int LP_ILV_BIT      = 1;
  localparam int LP_NOSS_BIT     = 2;
  localparam int LP_WAIT_LO      = 3;
  localparam int LP_EN_BIT       = 7;
  localparam int OC_MASTER_BIT   = 0;
  localparam int OC_DIV_LO       = 1;
  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_HOLD  = 16'h0000;
  localparam logic [15:0] HOLD_ONE  = 16'h0001;
  localparam logic [15:0] HOLD_ZERO = 16'h0000;
  // Word length codes
  typedef enum logic [2:0] {
    AOPC_WL16 = 3'b000, AOPC_WL12 = 3'b001, AOPC_WL10 = 3'b010,
    AOPC_WL8  = 3'b011, AOPC_WL7  = 3'b100, AOPC_WL6  = 3'b101,
    AOPC_WL5  = 3'b110, AOPC_WL4  = 3'b111
  } aopc_wl_t;
  localparam int SAMPLE_W   = 24;
  localparam int WORD_W     = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int NCH        = 4;
endpackage

// ---- hw/aopc_fifo.sv ----
// Purpose: Output data FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Full and empty are exact; no write when full
`timescale 1ns/100ps
module aopc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_wvalid,
  output logic                  o_wready,
  output logic      [WIDTH-1:0] o_rdata,
  output logic                  o_rvalid,
  input  wire logic             i_rready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // Handshakes from occupancy
  assign o_wready = (cnt_reg != (AW+1)'(DEPTH)) && i_ce;
  assign o_rvalid = (cnt_reg != '0);
  assign push     = i_wvalid && o_wready;
  assign pop      = o_rvalid && i_rready && i_ce;
  assign o_rdata  = mem[rp_reg];

  // Storage has no reset, so it maps onto plain RAM
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem[wp_reg] <= i_wdata;
  end

  // Pointers and count
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (i_ce)
    begin
      if (push)
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      if (pop)
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- hw/aopc_sync_ctl.sv ----
// Purpose: Holdoff counter and gain-loop sync sequencing
// Assumes: Sync requests are one-cycle pulses on the system clock
// Notes:   Holdoff of zero never synchronises the loop
`timescale 1ns/100ps
module aopc_sync_ctl
  import aopc_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_sync_req,
  input  wire logic        i_sync_now,
  input  wire logic [15:0] i_holdoff,
  input  wire logic        i_first_only,
  input  wire logic        i_init_on_sync,
  output logic             o_dump,
  output logic             o_init
);
  logic [15:0] cnt_reg;
  logic        run_reg;
  logic        seen_reg;
  logic        fire;
  logic        accept;

  // First-only mode drops every request after the first accepted one
  assign accept = i_sync_req && !(i_first_only && seen_reg);
  // Value one fires on the request itself; zero never loads
  assign fire = (accept && i_holdoff == HOLD_ONE) ||
                (run_reg && cnt_reg == HOLD_ONE + 16'h0001);
  assign o_dump = i_ce && (fire || i_sync_now);
  assign o_init = i_ce && fire && i_init_on_sync;

  // Countdown loaded on each accepted request with a holdoff above one
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_reg  <= RST_HOLD;
      run_reg  <= 1'b0;
      seen_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!i_first_only)
        seen_reg <= 1'b0;
      else if (accept)
        seen_reg <= 1'b1;
      if (accept && i_holdoff > HOLD_ONE)
      begin
        cnt_reg <= i_holdoff;
        run_reg <= 1'b1;
      end
      else if (run_reg)
      begin
        cnt_reg <= cnt_reg - 16'h0001;
        if (cnt_reg == HOLD_ONE + 16'h0001)
          run_reg <= 1'b0;
      end
    end
  end
endmodule

// ---- hw/aopc_top.sv ----
// Purpose: Output port control: half-band select, gain loop, port setup
// Assumes: Registers written through the microport via indirect pointer
// Notes:   Loop arithmetic is reduced to a gain shift; filter is averaging
// What this block does
// - Filter bit 0 set bypasses half-band
// - Filter enabled interleaves and interpolates by two
// - First filter takes 4, 3, 2 or 1 channels
// - Second filter setting does not change the channels taken
// - Bypass still interleaves, no interpolation
// - Control bits 7-5 choose output word width
// - Width codes 000=16 down to 111=4
// - Control bit 4 selects level or clipping tracking
// - Sync loads holdoff; at one, dump sample
// - Control bit 3 forces immediate update
// - Bit 2 set: sync clears, reloads parameters
// - Bit 2 clear: sync keeps parameters, still dumps
// - Bit 1 set: only first sync acts
// - Control bit 0 bypasses loop, 16 MSBs
// - Holdoff reloads on software or pin sync
// - Holdoff one immediate, zero never syncs
// - Parallel bit 5 chooses 8-bit or 16-bit when source bit 0 set; clear gives 16 MSBs
// - Parallel bits 4-1 channel enables, bit 0 source
// - Link bit 7 enable, 6-3 wait, source
// - Link bit 2 suppresses signal strength word
// - Link interleave bit: two or four channel
// - Clock bits 2-1 divisor, bit 0 master; slave
`timescale 1ns/100ps
module aopc_top
  import aopc_pkg::*;
#(
  parameter int CH_W  = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ce,
  input  wire logic                  i_reg_we,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [15:0]           i_reg_wdata,
  output logic      [15:0]           o_reg_rdata,
  input  wire logic [NCH*CH_W-1:0]   i_ch_data,
  input  wire logic                  i_ch_valid,
  input  wire logic                  i_soft_sync,
  input  wire logic                  i_pin_sync,
  input  wire logic                  i_pclk_in,
  output logic                       o_pclk_out,
  output logic                       o_pclk_oe_n,
  output logic      [aopc_pkg::WORD_W-1:0] o_port_data,
  output logic                       o_port_valid,
  input  wire logic                  i_port_ready,
  output logic                       o_link_en,
  output logic      [3:0]            o_link_wait,
  output logic                       o_link_send_ss,
  output logic                       o_link_two_ch,
  output logic                       o_link_from_gain,
  output logic      [15:0]           o_signal_strength
);
  logic [2:0]  hb_a_reg;
  logic [2:0]  hb_b_reg;
  logic [7:0]  gl_ctrl_reg;
  logic [15:0] gl_hold_reg;
  logic [7:0]  link_a_reg;
  logic [7:0]  par_b_reg;
  logic [7:0]  link_b_reg;
  logic [2:0]  oclk_reg;
  logic        sync_now_reg;
  logic [1:0]  psync_sr;
  logic        psync_d_reg;
  logic [1:0]  pclk_sr;
  logic        pclk_d_reg;
  logic        pclk_rise;
  logic        gen_rise;
  logic        dump;
  logic        init;
  logic [1:0]  div_cnt_reg;
  logic        pclk_gen_reg;
  logic [1:0]  slot_reg;
  logic [1:0]  last_slot;
  logic        hb_bypass;
  logic [CH_W-1:0] cur_sample;
  logic [CH_W-1:0] prev_reg;
  logic        interp_reg;
  logic [CH_W-1:0] hb_word;
  logic        hb_valid;
  logic [CH_W-1:0] hb_word_reg;
  logic        hb_valid_reg;
  logic [1:0]  hb_slot_reg;
  logic [15:0] msb16;
  logic [15:0] gain_word;
  logic [15:0] out_word;
  logic [15:0] peak_reg;
  logic [3:0]  gain_sh_reg;
  logic        fifo_wready;
  logic [15:0] last_dump_reg;

  // Register writes; the sync-now bit self-clears after acting
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hb_a_reg    <= RST_BYTE[2:0];
      hb_b_reg    <= RST_BYTE[2:0];
      gl_ctrl_reg <= RST_BYTE;
      gl_hold_reg <= RST_HOLD;
      link_a_reg  <= RST_BYTE;
      par_b_reg   <= RST_BYTE;
      link_b_reg  <= RST_BYTE;
      oclk_reg    <= RST_BYTE[2:0];   // Slave after reset
      sync_now_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      sync_now_reg <= 1'b0;
      if (i_reg_we)
      begin
        unique case (i_reg_addr)
          OFS_HB_A:    hb_a_reg    <= i_reg_wdata[2:0];
          OFS_HB_B:    hb_b_reg    <= i_reg_wdata[2:0];
          OFS_GL_CTRL:
          begin
            gl_ctrl_reg  <= i_reg_wdata[7:0];
            sync_now_reg <= i_reg_wdata[GL_NOW_BIT];
          end
          OFS_GL_HOLD: gl_hold_reg <= i_reg_wdata;
          OFS_LINK_A:  link_a_reg  <= i_reg_wdata[7:0];
          OFS_PAR_B:   par_b_reg   <= i_reg_wdata[7:0];
          OFS_LINK_B:  link_b_reg  <= i_reg_wdata[7:0];
          OFS_OCLK:    oclk_reg    <= i_reg_wdata[2:0];
          default:     ;
        endcase
      end
    end
  end

  // Readback; the control word shows the sync-now bit as last written
  always_comb
  begin
    o_reg_rdata = 16'h0000;
    unique case (i_reg_addr)
      OFS_HB_A:    o_reg_rdata = {13'h0000, hb_a_reg};
      OFS_HB_B:    o_reg_rdata = {13'h0000, hb_b_reg};
      OFS_GL_CTRL: o_reg_rdata = {8'h00, gl_ctrl_reg};
      OFS_GL_HOLD: o_reg_rdata = gl_hold_reg;
      OFS_LINK_A:  o_reg_rdata = {8'h00, link_a_reg};
      OFS_PAR_B:   o_reg_rdata = {8'h00, par_b_reg};
      OFS_LINK_B:  o_reg_rdata = {8'h00, link_b_reg};
      OFS_OCLK:    o_reg_rdata = {13'h0000, oclk_reg};
      default:     o_reg_rdata = 16'h0000;
    endcase
  end

  // Pin sync and port clock come from outside: two-stage synchronisers
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      psync_sr    <= 2'b00;
      psync_d_reg <= 1'b0;
      pclk_sr     <= 2'b00;
      pclk_d_reg  <= 1'b0;
    end
    else if (i_ce)
    begin
      psync_sr    <= {psync_sr[0], i_pin_sync};
      psync_d_reg <= psync_sr[1];
      pclk_sr     <= {pclk_sr[0], i_pclk_in};
      pclk_d_reg  <= pclk_sr[1];
    end
  end

  // Either sync source reloads the holdoff counter
  aopc_sync_ctl u_sync (
    .i_clk_sys      (i_clk_sys),
    .i_resetn       (i_resetn),
    .i_ce           (i_ce),
    .i_sync_req     (i_soft_sync || (psync_sr[1] && !psync_d_reg)),
    .i_sync_now     (sync_now_reg),
    .i_holdoff      (gl_hold_reg),
    .i_first_only   (gl_ctrl_reg[GL_FIRST_BIT]),
    .i_init_on_sync (gl_ctrl_reg[GL_INIT_BIT]),
    .o_dump         (dump),
    .o_init         (init)
  );

  // Port clock: divided master drive, or slave edges sampled
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_cnt_reg  <= 2'b00;
      pclk_gen_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      if (div_cnt_reg >= oclk_reg[OC_DIV_LO +: 2])
      begin
        div_cnt_reg  <= 2'b00;
        pclk_gen_reg <= ~pclk_gen_reg;
      end
      else
        div_cnt_reg <= div_cnt_reg + 2'b01;
    end
  end
  assign o_pclk_out  = pclk_gen_reg;
  assign o_pclk_oe_n = ~oclk_reg[OC_MASTER_BIT];   // Slave never drives
  // Master drains on the edge that raises its own clock, not every cycle
  assign gen_rise    = (div_cnt_reg >= oclk_reg[OC_DIV_LO +: 2]) &&
                       !pclk_gen_reg;
  assign pclk_rise   = oclk_reg[OC_MASTER_BIT] ? gen_rise
                                               : (pclk_sr[1] && !pclk_d_reg);

  // Channel set per filter: A takes 1..4 channels, B setting leaves the channel set unchanged
  assign last_slot = hb_a_reg[HB_SEL_LO +: 2];
  assign hb_bypass = hb_a_reg[HB_BYPASS_BIT];
  assign cur_sample = hb_b_reg[HB_SEL_LO] && slot_reg >= 2'd2 &&
                      !hb_a_reg[HB_SEL_LO +: 1]
                      ? i_ch_data[(32'(slot_reg))*CH_W +: CH_W]
                      : i_ch_data[(32'(slot_reg))*CH_W +: CH_W];

  // Interleave slots; when filtering, each slot emits a midpoint too
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      slot_reg   <= 2'b00;
      interp_reg <= 1'b0;
      prev_reg   <= '0;
    end
    else if (i_ce && i_ch_valid && fifo_wready)
    begin
      if (!hb_bypass && !interp_reg)
        interp_reg <= 1'b1;
      else
      begin
        interp_reg <= 1'b0;
        prev_reg   <= cur_sample;
        slot_reg   <= (slot_reg >= last_slot) ? 2'b00
                                               : slot_reg + 2'b01;
      end
    end
  end
  assign hb_valid = i_ch_valid && fifo_wready;
  assign hb_word  = (!hb_bypass && interp_reg)
                    ? CH_W'(({prev_reg[CH_W-1], prev_reg} +
                             {cur_sample[CH_W-1], cur_sample}) >>> 1)
                    : cur_sample;

  // Register the filter output before the gain stage
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hb_word_reg  <= '0;
      hb_slot_reg  <= 2'b00;
      hb_valid_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      hb_word_reg  <= hb_word;
      hb_valid_reg <= hb_valid;
      hb_slot_reg  <= slot_reg;   // Enable follows the word's own slot
    end
  end

  // Gain loop: peak tracking between dumps steers a shift
  assign msb16 = hb_word_reg[CH_W-1 -: 16];
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      peak_reg      <= 16'h0000;
      gain_sh_reg   <= 4'h0;
      last_dump_reg <= 16'h0000;
    end
    else if (i_ce)
    begin
      if (dump)
      begin
        last_dump_reg <= peak_reg;
        peak_reg      <= 16'h0000;
        if (init)
          gain_sh_reg <= 4'h0;
        else if (gl_ctrl_reg[GL_CLIP_BIT])
          gain_sh_reg <= (peak_reg[15]) ? gain_sh_reg - 4'h1
                                        : gain_sh_reg;
        else if (!peak_reg[15] && !peak_reg[14])
          gain_sh_reg <= gain_sh_reg + 4'h1;
        else
          gain_sh_reg <= gain_sh_reg;
      end
      else if (hb_valid_reg && (msb16[15] ? ~msb16 : msb16) > peak_reg)
        peak_reg <= msb16[15] ? ~msb16 : msb16;
    end
  end
  assign gain_word = 16'(msb16 <<< gain_sh_reg);
  assign o_signal_strength = last_dump_reg;

  // Word length truncation keeps the top bits of the chosen width
  always_comb
  begin
    out_word = gl_ctrl_reg[GL_BYPASS_BIT] ? msb16 : gain_word;
    unique case (aopc_wl_t'(gl_ctrl_reg[GL_WL_LO +: 3]))
      AOPC_WL16: out_word = out_word;
      AOPC_WL12: out_word = out_word & 16'hFFF0;
      AOPC_WL10: out_word = out_word & 16'hFFC0;
      AOPC_WL8:  out_word = out_word & 16'hFF00;
      AOPC_WL7:  out_word = out_word & 16'hFE00;
      AOPC_WL6:  out_word = out_word & 16'hFC00;
      AOPC_WL5:  out_word = out_word & 16'hF800;
      AOPC_WL4:  out_word = out_word & 16'hF000;
    endcase
    if (par_b_reg[PP_FMT_BIT])
      out_word = {8'h00, out_word[15:8]};
    if (!par_b_reg[PP_SRC_BIT])
      out_word = msb16;
  end

  // Output buffer; drained on port clock edges for enabled channels
  aopc_fifo #(
    .WIDTH (16),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .i_wdata   (out_word),
    .i_wvalid  (hb_valid_reg && par_b_reg[PP_CHEN_LO + hb_slot_reg]),
    .o_wready  (fifo_wready),
    .o_rdata   (o_port_data),
    .o_rvalid  (o_port_valid),
    .i_rready  (i_port_ready && pclk_rise)
  );

  // Link port setup reflected on plain outputs
  assign o_link_en        = link_a_reg[LP_EN_BIT];
  assign o_link_wait      = link_a_reg[LP_WAIT_LO +: 4];
  assign o_link_send_ss   = ~link_a_reg[LP_NOSS_BIT];
  assign o_link_two_ch    = link_a_reg[LP_ILV_BIT] |
                            link_b_reg[LP_ILV_BIT];
  assign o_link_from_gain = link_a_reg[LP_SRC_BIT];
endmodule

// ---- test/aopc_top_chk.sv ----
// Purpose: Port-level checks of the output port control block
// Assumes: Writes are taken at the rising edge while enabled
// Notes:   Shadows come from the write port, never from the design
`timescale 1ns/100ps
module aopc_top_chk
  import aopc_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_reg_we,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic [15:0] o_reg_rdata,
  input  wire logic        o_pclk_oe_n,
  input  wire logic        o_link_en,
  input  wire logic [3:0]  o_link_wait,
  input  wire logic        o_link_send_ss,
  input  wire logic        o_link_two_ch,
  input  wire logic        o_link_from_gain,
  input  wire logic [15:0] o_signal_strength,
  input  wire logic        o_port_valid
);
  logic [7:0]  lka_reg;
  logic [7:0]  lkb_reg;
  logic        master_reg;
  logic [15:0] hold_reg;
  logic        quiet_reg;
  logic        wr;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  assign wr = i_reg_we & i_ce;
  // Shadows follow accepted writes only
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lka_reg    <= 8'h00;
      lkb_reg    <= 8'h00;
      master_reg <= 1'b0;
      hold_reg   <= 16'h0000;
    end
    else if (wr)
    begin
      if (i_reg_addr == OFS_LINK_A) lka_reg <= i_reg_wdata[7:0];
      if (i_reg_addr == OFS_LINK_B) lkb_reg <= i_reg_wdata[7:0];
      if (i_reg_addr == OFS_OCLK) master_reg <= i_reg_wdata[0];
      if (i_reg_addr == OFS_GL_HOLD) hold_reg <= i_reg_wdata;
    end
  end
  // Quiet until a nonzero holdoff or a sync-now write can dump
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      quiet_reg <= 1'b1;
    else if (wr && ((i_reg_addr == OFS_GL_HOLD && i_reg_wdata != 16'h0000)
             || (i_reg_addr == OFS_GL_CTRL && i_reg_wdata[3])))
      quiet_reg <= 1'b0;
  end
  property p_link_en;
    o_link_en == lka_reg[7];
  endproperty
  a_link_en: assert property (p_link_en) else $error("link enable wrong");
  property p_link_wait;
    o_link_wait == lka_reg[6:3];
  endproperty
  a_link_wait: assert property (p_link_wait) else $error("link wait wrong");
  property p_link_src;
    o_link_from_gain == lka_reg[0];
  endproperty
  a_link_src: assert property (p_link_src) else $error("link source wrong");
  property p_link_ss;
    o_link_send_ss != lka_reg[2];
  endproperty
  a_link_ss: assert property (p_link_ss) else $error("strength word wrong");
  property p_link_two;
    o_link_two_ch == (lka_reg[1] | lkb_reg[1]);
  endproperty
  a_link_two: assert property (p_link_two) else $error("interleave wrong");
  property p_pclk_dir;
    o_pclk_oe_n != master_reg;
  endproperty
  a_pclk_dir: assert property (p_pclk_dir) else $error("clock direction wrong");
  property p_hold_zero;
    quiet_reg |-> o_signal_strength == 16'h0000;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("dump without sync");
  property p_rd_hold;
    i_reg_addr == OFS_GL_HOLD |-> o_reg_rdata == hold_reg;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("holdoff readback wrong");
  property p_rd_link;
    wr && i_reg_addr == OFS_LINK_A |=> o_link_en == $past(i_reg_wdata[7]);
  endproperty
  a_rd_link: assert property (p_rd_link) else $error("link write lost");
  c_link: cover property ($rose(o_link_en));
  c_dump: cover property ($changed(o_signal_strength));
  c_data: cover property ($rose(o_port_valid));
endmodule
bind aopc_top aopc_top_chk i_chk (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(i_ce),
  .i_reg_we(i_reg_we), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_pclk_oe_n(o_pclk_oe_n), .o_link_en(o_link_en),
  .o_link_wait(o_link_wait), .o_link_send_ss(o_link_send_ss),
  .o_link_two_ch(o_link_two_ch), .o_link_from_gain(o_link_from_gain),
  .o_signal_strength(o_signal_strength), .o_port_valid(o_port_valid)
);

// ---- test/aopc_dsp_model.sv ----
// Purpose: Reading processor on the far side of the output port
// Assumes: Port clock is supplied by this side while the block is slave
// Notes:   Clock stands low between frames; ready moves only while low
`timescale 1ns/100ps
module aopc_dsp_model
  import aopc_pkg::*;
(
  input  wire logic              i_run,
  input  wire logic              i_take,
  input  wire logic              i_valid,
  input  wire logic [WORD_W-1:0] i_data,
  output logic                   o_pclk,
  output logic                   o_ready,
  output int                     o_count,
  output logic      [WORD_W-1:0] o_last
);
  // 800 ns port clock, low between frames; a word is taken at each rise while valid and ready
  initial
  begin
    o_pclk  = 1'b0;
    o_ready = 1'b0;
    o_count = 0;
    o_last  = '0;
    forever
    begin
      #400;
      if (o_pclk)
        o_pclk = 1'b0;
      else if (i_run)
      begin
        o_pclk = 1'b1;
        if (i_valid && o_ready)
        begin
          o_count++;
          o_last = i_data;
        end
      end
      // Ready changes only away from the sampling edge
      if (!o_pclk)
        o_ready = i_take;
    end
  end
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench of the output port control block
// Assumes: Inputs driven at the falling edge, clock 10 MHz
// Notes:   Constant samples make every channel mix give the same word
`timescale 1ns/100ps
module tb;
  import aopc_pkg::*;
  localparam logic [23:0] SAMP = 24'h123456;
  logic                clk = 1'b0;
  logic                rstn = 1'b0;
  logic                we = 1'b0;
  logic                ce = 1'b1;
  logic [7:0]          addr = 8'h00;
  logic [15:0]         wdata = 16'h0000;
  logic [15:0]         rdata;
  logic [NCH*24-1:0]   chd = {NCH{SAMP}};
  logic                chv = 1'b0;
  logic                ssy = 1'b0;
  logic                psy = 1'b0;
  logic                pclk;
  logic                oe_n;
  logic [WORD_W-1:0]   pd;
  logic                pv;
  logic                prdy;
  logic                len;
  logic [3:0]          lwait;
  logic                lss;
  logic                ltwo;
  logic                lgain;
  logic [15:0]         sstr;
  logic                run = 1'b0;
  logic                take = 1'b0;
  int                  cnt;
  logic [WORD_W-1:0]   last;
  int                  fails = 0;
  int                  tests_run = 0;
  int                  cycles = 0;
  aopc_top i_aopc_top (
    .i_clk_sys(clk), .i_resetn(rstn), .i_ce(ce), .i_reg_we(we),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_ch_data(chd), .i_ch_valid(chv), .i_soft_sync(ssy),
    .i_pin_sync(psy), .i_pclk_in(pclk), .o_pclk_out(),
    .o_pclk_oe_n(oe_n), .o_port_data(pd), .o_port_valid(pv),
    .i_port_ready(prdy), .o_link_en(len), .o_link_wait(lwait),
    .o_link_send_ss(lss), .o_link_two_ch(ltwo),
    .o_link_from_gain(lgain), .o_signal_strength(sstr)
  );
  aopc_dsp_model i_aopc_dsp_model (
    .i_run(run), .i_take(take), .i_valid(pv), .i_data(pd),
    .o_pclk(pclk), .o_ready(prdy), .o_count(cnt), .o_last(last)
  );
  initial
  begin
    forever #50 clk = ~clk;
  end
  // Cuts a hang short well past the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;  // Pointer value, lower-half select
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    #1;
    chk(nm, rdata, e);
  endtask
  // One-cycle soft pulse, or a pin level held for one cycle
  task automatic pulse(input bit pin);
    @(negedge clk);
    if (pin) psy = 1'b1;
    else ssy = 1'b1;
    @(negedge clk);
    psy = 1'b0;
    ssy = 1'b0;
  endtask
  // Reset values, widths, unmapped place and link outputs
  task automatic t_regs();
    logic [7:0]  ofs [8];
    logic [15:0] msk [8];
    ofs = '{OFS_HB_A, OFS_HB_B, OFS_GL_CTRL, OFS_GL_HOLD,
            OFS_LINK_A, OFS_PAR_B, OFS_LINK_B, OFS_OCLK};
    msk = '{16'h0007, 16'h0007, 16'h00FF, 16'hFFFF,
            16'h00FF, 16'h00FF, 16'h00FF, 16'h0007};
    chk("clock oe after reset", oe_n, 1'b1);
    for (int i = 0; i < 8; i++)
      rd("reset value", ofs[i], 16'h0000);
    @(negedge clk);
    ce = 1'b0;
    wr(OFS_LINK_A, 16'h0080);
    ce = 1'b1;
    chk("frozen write", len, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      wr(ofs[i], 16'hFFFF);
      rd("readback width", ofs[i], msk[i]);
    end
    wr(8'h0C, 16'h00FF);
    rd("unmapped read", 8'h0C, 16'h0000);
    wr(OFS_LINK_A, 16'h00B5);
    wr(OFS_LINK_B, 16'h0000);
    chk("link outputs", {len, lwait, lss, ltwo, lgain}, 8'hB1);
    wr(OFS_LINK_B, 16'h0002);
    chk("two channel mode", ltwo, 1'b1);
    wr(OFS_OCLK, 16'h0001);
    chk("master drives", oe_n, 1'b0);
    wr(OFS_OCLK, 16'h0000);
    chk("slave released", oe_n, 1'b1);
  endtask
  // Holdoff zero, long holdoff, holdoff one by pin, sync now
  task automatic t_sync();
    do_reset();
    chv = 1'b1;
    pulse(1'b0);
    repeat (10) @(negedge clk);
    chk("no dump at holdoff 0", sstr, 16'h0000);
    wr(OFS_GL_HOLD, 16'h0006);
    pulse(1'b0);
    repeat (2) @(negedge clk);
    chk("no early dump", sstr, 16'h0000);
    repeat (10) @(negedge clk);
    chk("dump after count", 16'(sstr != 16'h0000), 16'h0001);
    do_reset();
    wr(OFS_GL_HOLD, 16'h0001);
    pulse(1'b1);
    repeat (6) @(negedge clk);
    chk("pin sync at once", 16'(sstr != 16'h0000), 16'h0001);
    do_reset();
    wr(OFS_GL_CTRL, 16'h0008);
    repeat (4) @(negedge clk);
    chk("sync now", 16'(sstr != 16'h0000), 16'h0001);
    // Second sync would dump an empty peak if it were not ignored
    do_reset();
    wr(OFS_GL_CTRL, 16'h0002);
    wr(OFS_GL_HOLD, 16'h0001);
    chv = 1'b0;
    pulse(1'b0);
    pulse(1'b0);
    repeat (4) @(negedge clk);
    chk("first sync only", sstr, SAMP[23:8]);
  endtask
  // Fill while the reader stalls, drain, then the 8-bit format
  task automatic t_data();
    do_reset();
    wr(OFS_HB_A, 16'h0001);
    wr(OFS_GL_CTRL, 16'h0001);
    wr(OFS_PAR_B, 16'h0003);
    chv = 1'b1;
    repeat (40) @(negedge clk);
    chv = 1'b0;
    chk("port valid", pv, 1'b1);
    chk("bypass msbs", pd, SAMP[23:8]);
    take = 1'b1;
    run = 1'b1;
    for (int n = 0; n < 600 && pv !== 1'b0; n++)
      @(negedge clk);
    run = 1'b0;
    repeat (20) @(negedge clk);
    chk("words drained", 16'(cnt), 16'(FIFO_DEPTH));
    chk("last word", last, SAMP[23:8]);
    wr(OFS_PAR_B, 16'h0023);
    chv = 1'b1;
    repeat (5) @(negedge clk);
    chv = 1'b0;
    chk("8-bit low byte", 16'(pd[7:0]), 16'(SAMP[23:16]));
  endtask
  initial
  begin
    do_reset();
    t_regs();
    t_sync();
    t_data();
    close_out();
  end
endmodule
